// >>> shared/uir_pkg.sv
/*
 * uir_pkg: shared constants and carriers for the isolated repeater.
 * assumes a 250 MHz system clock and straps that stay fixed in use.
 */
package uir_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 250;
  localparam int FS_BIT_NS_X10 = 833;
  localparam int LS_BIT_NS_X10 = 6667;
  localparam int FS_BIT_CYC = (FS_BIT_NS_X10 * CLK_MHZ) / 10000;
  localparam int LS_BIT_CYC = (LS_BIT_NS_X10 * CLK_MHZ) / 10000;
  localparam int PWR_LOSS_BITS = 32;
  localparam int REFRESH_BITS = 12;
  localparam int WATCHDOG_BITS = 36;
  localparam int IDLE_END_BITS = 7;
  localparam int EOP_SE0_MIN_BITS = 1;
  localparam int FWD_DELAY_CYC = 8;
  localparam int FIFO_DEPTH = 32;

  localparam logic [1:0] SYM_SE0 = 2'h0;
  localparam logic [1:0] SYM_J = 2'h1;
  localparam logic [1:0] SYM_K = 2'h2;

  typedef struct packed {
    logic dp;
    logic dm;
  } uir_line_t;

  typedef struct packed {
    logic [1:0] sym;
  } uir_word_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_UP2DN = 2'h1,
    ST_DN2UP = 2'h2,
    ST_DRAIN = 2'h3
  } uir_state_t;

endpackage

// >>> logic/uir_repeater.sv
/*
 * uir_repeater: direction-sensing repeater logic and its line fifo.
 * assumes the line inputs are asynchronous and that both speed straps
 * are tied to the same level by the board.
 */
`timescale 1ns/1ps

// ************************************************************
// fifo
// ************************************************************
module uir_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } uir_fifo_st_t;
  uir_fifo_st_t st_r, st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic push, pop;

  assign in_ready_out = (st_r.cnt != DEPTH[AW:0]);
  assign out_valid_out = (st_r.cnt != '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem_r[st_r.rp];

  always_comb begin
    st_nxt = st_r;
    if (flush_in) begin
      st_nxt = '0;
    end else begin
      if (push) st_nxt.wp = st_r.wp + 1'b1;
      if (pop) st_nxt.rp = st_r.rp + 1'b1;
      if (push && !pop) st_nxt.cnt = st_r.cnt + 1'b1;
      if (pop && !push) st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push) mem_r[st_r.wp] <= in_data_in;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) st_r <= '0;
    else st_r <= st_nxt;
  end
endmodule

// ************************************************************
// repeater
// ************************************************************
// What this block does
// - downstream speed strap picks full or low speed timing and J/K sense.
// - pull-up enable input switches the upstream pull-up resistor.
// - pull-up enable low keeps all drivers off and upstream detached.
// - upstream power loss releases downstream drivers within 32 bit times.
// - downstream drivers come up released after power-up.
// - downstream power loss drops pull-up and upstream drivers in 32 bits.
// - idle side that first leaves J sets the direction toward the other.
// - forward until EOP or long idle, then release and watch both again.
// - receiving side stays released, the driven side's inputs ignored meanwhile.
// - only J, K or SE0 are ever reproduced, never SE1; any SE0 that outlasts the input filter is passed on.
// - receiver threshold glitches are filtered before symbol decision.
// - output follows input with a constant delay keeping bit timing.
// - traffic passes unchanged apart from filtered glitches and SE1, which goes out as J.
// - refresh state after 12 quiet bits; default after 36 silent bits.
// - pull-down keep strap sampled once after reset release.
module uir_repeater (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire uir_pkg::uir_line_t upstream_line_in,
  output uir_pkg::uir_line_t upstream_line_out,
  output logic upstream_line_oe_out,
  input wire uir_pkg::uir_line_t downstream_line_in,
  output uir_pkg::uir_line_t downstream_line_out,
  output logic downstream_line_oe_out,
  input wire logic upstream_speed_select_in,
  input wire logic downstream_speed_select_in,
  input wire logic pullup_enable_in,
  input wire logic upstream_powered_in,
  input wire logic downstream_powered_in,
  input wire logic pulldown_keep_strap_in,
  output logic upstream_pullup_dp_out,
  output logic upstream_pullup_dm_out,
  output logic downstream_pulldown_out,
  output logic [1:0] state_out
);
  import uir_pkg::*;

  localparam int CW = 16;

  typedef struct packed {
    logic [2:0] s_udp, s_udm, s_ddp, s_ddm, s_pin, s_upw, s_dpw;
    logic [1:0] s_spd, s_pdk;
    logic [1:0] up_sym, dn_sym;
    logic [1:0] up_cand, dn_cand;
    logic [3:0] up_flt, dn_flt;
    uir_state_t state;
    logic [CW-1:0] bit_cnt;
    logic [7:0] quiet_bits;
    logic [7:0] silent_bits;
    logic [7:0] up_loss_bits;
    logic [7:0] dn_loss_bits;
    logic [7:0] se0_bits;
    logic [3:0] dly;
    logic [1:0] out_sym;
    logic out_oe;
    logic pdk_done;
    logic pdk;
    logic to_up;
    logic [3:0] settle;
    logic pin_lvl, upw_lvl, dpw_lvl;
  } uir_st_t;
  uir_st_t st_r, st_nxt;

  logic fs, pin_ok, up_pw, dn_pw, dn_to_up;
  logic [1:0] up_raw, dn_raw, src_sym, fifo_sym;
  logic [CW-1:0] bit_cyc;
  logic fifo_in_ready, fifo_out_valid, fifo_pop, fifo_flush, fifo_push;

  assign fs = st_r.s_spd[1];
  // slow pins, agreed levels only
  assign pin_ok = st_r.pin_lvl;
  assign up_pw = st_r.upw_lvl;
  assign dn_pw = st_r.dpw_lvl;
  assign bit_cyc = fs ? CW'(FS_BIT_CYC) : CW'(LS_BIT_CYC);
  assign dn_to_up = (st_r.state == ST_DN2UP);

  function automatic logic [1:0] decode(input logic dp, input logic dm,
                                        input logic full);
    logic [1:0] s;
    s = SYM_SE0;
    if (dp && !dm) s = full ? SYM_J : SYM_K;
    else if (!dp && dm) s = full ? SYM_K : SYM_J;
    else if (dp && dm) s = SYM_J;
    return s;
  endfunction

  assign up_raw = decode(st_r.s_udp[2], st_r.s_udm[2], fs);
  assign dn_raw = decode(st_r.s_ddp[2], st_r.s_ddm[2], fs);
  assign src_sym = dn_to_up ? st_r.dn_sym : st_r.up_sym;
  // idle empties the fifo so each packet starts aligned
  assign fifo_flush = (st_r.state == ST_IDLE);
  assign fifo_pop = fifo_out_valid && (st_r.dly == 4'(FWD_DELAY_CYC));
  assign fifo_push = (st_r.state == ST_UP2DN) || dn_to_up;

  uir_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .flush_in(fifo_flush),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(src_sym),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_sym)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.s_udp = {st_r.s_udp[1:0], upstream_line_in.dp};
    st_nxt.s_udm = {st_r.s_udm[1:0], upstream_line_in.dm};
    st_nxt.s_ddp = {st_r.s_ddp[1:0], downstream_line_in.dp};
    st_nxt.s_ddm = {st_r.s_ddm[1:0], downstream_line_in.dm};
    st_nxt.s_pin = {st_r.s_pin[1:0], pullup_enable_in};
    st_nxt.s_upw = {st_r.s_upw[1:0], upstream_powered_in};
    st_nxt.s_dpw = {st_r.s_dpw[1:0], downstream_powered_in};
    st_nxt.s_spd = {st_r.s_spd[0], downstream_speed_select_in};
    st_nxt.s_pdk = {st_r.s_pdk[0], pulldown_keep_strap_in};

    // slow pins change once second and third stage agree
    if (st_r.s_pin[1] == st_r.s_pin[2]) st_nxt.pin_lvl = st_r.s_pin[2];
    if (st_r.s_upw[1] == st_r.s_upw[2]) st_nxt.upw_lvl = st_r.s_upw[2];
    if (st_r.s_dpw[1] == st_r.s_dpw[2]) st_nxt.dpw_lvl = st_r.s_dpw[2];

    if (up_raw != st_r.up_cand) begin
      st_nxt.up_cand = up_raw;
      st_nxt.up_flt = '0;
    end else if (st_r.up_flt != 4'h3) begin
      st_nxt.up_flt = st_r.up_flt + 4'h1;
    end else begin
      st_nxt.up_sym = st_r.up_cand;
    end
    if (dn_raw != st_r.dn_cand) begin
      st_nxt.dn_cand = dn_raw;
      st_nxt.dn_flt = '0;
    end else if (st_r.dn_flt != 4'h3) begin
      st_nxt.dn_flt = st_r.dn_flt + 4'h1;
    end else begin
      st_nxt.dn_sym = st_r.dn_cand;
    end

    st_nxt.bit_cnt = (st_r.bit_cnt >= bit_cyc - 1'b1) ? '0 :
                     st_r.bit_cnt + 1'b1;

    if (up_pw) st_nxt.up_loss_bits = '0;
    else if (st_r.bit_cnt == '0 && st_r.up_loss_bits != 8'hFF)
      st_nxt.up_loss_bits = st_r.up_loss_bits + 8'h1;
    if (dn_pw) st_nxt.dn_loss_bits = '0;
    else if (st_r.bit_cnt == '0 && st_r.dn_loss_bits != 8'hFF)
      st_nxt.dn_loss_bits = st_r.dn_loss_bits + 8'h1;

    // quiet and silence counters
    // idle J only: data edges restart the count
    if (src_sym != SYM_J) st_nxt.silent_bits = '0;
    else if (st_r.bit_cnt == '0 && st_r.silent_bits != 8'hFF)
      st_nxt.silent_bits = st_r.silent_bits + 8'h1;
    if (st_r.quiet_bits >= 8'(REFRESH_BITS)) st_nxt.quiet_bits = '0;
    else if (st_r.bit_cnt == '0)
      st_nxt.quiet_bits = st_r.quiet_bits + 8'h1;

    if (st_r.dly != 4'(FWD_DELAY_CYC)) st_nxt.dly = st_r.dly + 4'h1;
    if (fifo_pop) st_nxt.out_sym = fifo_sym;
    if (st_r.quiet_bits >= 8'(REFRESH_BITS) && !fifo_out_valid)
      st_nxt.out_sym = st_r.out_sym;

    case (st_r.state)
      ST_IDLE: begin
        st_nxt.out_oe = 1'b0;
        st_nxt.dly = '0;
        st_nxt.se0_bits = '0;
        st_nxt.silent_bits = '0;
        st_nxt.out_sym = SYM_J;
        st_nxt.settle = '0;
        if (pin_ok && up_pw && dn_pw) begin
          if (st_r.up_sym != SYM_J) begin
            st_nxt.state = ST_UP2DN;
            st_nxt.to_up = 1'b0;
          end else if (st_r.dn_sym != SYM_J) begin
            st_nxt.state = ST_DN2UP;
            st_nxt.to_up = 1'b1;
          end
        end
      end
      ST_UP2DN, ST_DN2UP: begin
        if (fifo_pop) st_nxt.out_oe = 1'b1;
        if (src_sym == SYM_SE0) begin
          if (st_r.bit_cnt == '0 && st_r.se0_bits != 8'hFF)
            st_nxt.se0_bits = st_r.se0_bits + 8'h1;
        end else begin
          st_nxt.se0_bits = '0;
          if (src_sym == SYM_J &&
              st_r.se0_bits >= 8'(EOP_SE0_MIN_BITS))
            st_nxt.state = ST_DRAIN;
        end
        if (st_r.silent_bits >= 8'(IDLE_END_BITS) ||
            st_r.silent_bits >= 8'(WATCHDOG_BITS) ||
            !fifo_in_ready)
          st_nxt.state = ST_DRAIN;
      end
      ST_DRAIN: begin
        // hold J until our own echo has left the input filters
        if (fifo_out_valid) begin
          st_nxt.settle = '0;
        end else if (st_r.settle != 4'hF) begin
          st_nxt.settle = st_r.settle + 4'h1;
        end else begin
          st_nxt.state = ST_IDLE;
        end
      end
      default: st_nxt.state = ST_IDLE;
    endcase

    if (!pin_ok || !up_pw || !dn_pw ||
        st_r.up_loss_bits >= 8'(PWR_LOSS_BITS) ||
        st_r.dn_loss_bits >= 8'(PWR_LOSS_BITS)) begin
      st_nxt.state = ST_IDLE;
      st_nxt.out_oe = 1'b0;
    end

    // strap caught once
    // wait until the strap has passed its synchroniser
    if (!st_r.pdk_done && st_r.bit_cnt == CW'(4'h2)) begin
      st_nxt.pdk_done = 1'b1;
      st_nxt.pdk = st_r.s_pdk[1];
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // lines read as idle J until the filters have real samples
      st_r <= '0;
      st_r.up_sym <= SYM_J;
      st_r.up_cand <= SYM_J;
      st_r.dn_sym <= SYM_J;
      st_r.dn_cand <= SYM_J;
    end else begin
      st_r <= st_nxt;
    end
  end

  function automatic uir_line_t encode(input logic [1:0] s,
                                       input logic full);
    uir_line_t l;
    l = '0;
    if (s == SYM_J) l = full ? 2'b10 : 2'b01;
    else if (s == SYM_K) l = full ? 2'b01 : 2'b10;
    return l;
  endfunction

  assign upstream_line_out = encode(st_r.out_sym, fs);
  assign downstream_line_out = encode(st_r.out_sym, fs);
  // released from reset
  // direction is held through the drain so the tail is not cut
  assign upstream_line_oe_out = st_r.out_oe && st_r.to_up && dn_pw &&
                                (st_r.state != ST_IDLE);
  assign downstream_line_oe_out = st_r.out_oe && !st_r.to_up && up_pw &&
                                  (st_r.state != ST_IDLE);
  // pull-up dropped on downstream power loss
  // one bit early covers the synchroniser lag
  assign upstream_pullup_dp_out = pin_ok && fs &&
                                  (st_r.dn_loss_bits < 8'(PWR_LOSS_BITS - 1));
  assign upstream_pullup_dm_out = pin_ok && !fs &&
                                  (st_r.dn_loss_bits < 8'(PWR_LOSS_BITS - 1));
  assign downstream_pulldown_out = st_r.pdk || !st_r.pdk_done;
  assign state_out = st_r.state;
endmodule

// >>> tb/uir_line_model.sv
/* line partner: host cable or peripheral on one side.
   assumes the pull-up holds a released line at J. */
`timescale 1ns/1ps
module uir_line_model import uir_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic fs_in,
  input wire logic oe_in,
  input wire uir_line_t dut_in,
  output uir_line_t line_out
);
  logic busy = 1'b0;
  logic [1:0] sym = SYM_J;
  function automatic uir_line_t enc(input logic [1:0] s);
    uir_line_t l;
    l.dp = s != SYM_SE0 && ((s == SYM_J) == fs_in);
    l.dm = s != SYM_SE0 && ((s == SYM_J) != fs_in);
    return l;
  endfunction
  assign line_out = busy ? enc(sym) : oe_in ? dut_in : enc(SYM_J);
  // packet ends in two SE0 bits then J
  task automatic send(input logic [7:0] bits);
    int bc;
    bc = fs_in ? FS_BIT_CYC : LS_BIT_CYC;
    busy = 1'b1;
    for (int i = 0; i < 11; i++) begin
      sym = i > 9 ? SYM_J : i > 7 ? SYM_SE0 : bits[i] ? SYM_K : SYM_J;
      repeat (bc) @(posedge clk_sys_in);
      #1;
    end
    busy = 1'b0;
  endtask
endmodule

// >>> tb/uir_repeater_chk.sv
/* port checker for uir_repeater.
   assumes it is bound to every uir_repeater instance. */
`timescale 1ns/1ps
module uir_repeater_chk import uir_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire uir_line_t upstream_line_out,
  input wire logic upstream_line_oe_out,
  input wire uir_line_t downstream_line_out,
  input wire logic downstream_line_oe_out,
  input wire logic downstream_speed_select_in,
  input wire logic pullup_enable_in,
  input wire logic upstream_powered_in,
  input wire logic downstream_powered_in,
  input wire logic upstream_pullup_dp_out,
  input wire logic upstream_pullup_dm_out,
  input wire logic downstream_pulldown_out,
  input wire logic [1:0] state_out
);
  int lim;
  logic [15:0] up_off_r, dn_off_r;
  assign lim = PWR_LOSS_BITS *
    (downstream_speed_select_in ? FS_BIT_CYC : LS_BIT_CYC);
  // cycles each side has been unpowered
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      up_off_r <= 16'h0;
      dn_off_r <= 16'h0;
    end else begin
      up_off_r <= upstream_powered_in ? 16'h0 :
                  up_off_r + {15'h0, ~&up_off_r};
      dn_off_r <= downstream_powered_in ? 16'h0 :
                  dn_off_r + {15'h0, ~&dn_off_r};
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  a_enable_low_idle:
    assert property (!pullup_enable_in [*8] |-> !upstream_line_oe_out &&
      !downstream_line_oe_out) else $error("driver on, enable low");
  a_enable_low_pullup:
    assert property (!pullup_enable_in [*8] |-> !upstream_pullup_dp_out &&
      !upstream_pullup_dm_out) else $error("pull-up on, enable low");
  a_one_direction:
    assert property (!(upstream_line_oe_out && downstream_line_oe_out))
      else $error("both sides driving");
  a_dn_drive_state:
    assert property (downstream_line_oe_out |-> state_out inside
      {2'h1, 2'h3}) else $error("downstream drive in wrong state");
  a_up_drive_state:
    assert property (upstream_line_oe_out |-> state_out inside
      {2'h2, 2'h3}) else $error("upstream drive in wrong state");
  a_no_se1_out:
    assert property (!(downstream_line_oe_out && &downstream_line_out) &&
      !(upstream_line_oe_out && &upstream_line_out)) else $error("SE1 out");
  a_pullup_fs_line:
    assert property (upstream_pullup_dp_out |-> downstream_speed_select_in
      && !upstream_pullup_dm_out) else $error("dp pull-up at low speed");
  a_pullup_ls_line:
    assert property (upstream_pullup_dm_out |-> !downstream_speed_select_in)
      else $error("dm pull-up at full speed");
  a_up_loss_release:
    assert property (up_off_r > lim |-> !downstream_line_oe_out)
      else $error("downstream held after upstream loss");
  a_dn_loss_release:
    assert property (dn_off_r > lim |-> !upstream_line_oe_out &&
      !upstream_pullup_dp_out && !upstream_pullup_dm_out)
      else $error("upstream held after downstream loss");
  a_pulldown_once:
    assert property (!$rose(downstream_pulldown_out))
      else $error("pull-down reconnected");
  a_dir_start_up:
    assert property ($rose(state_out == 2'h2) |-> ##[1:20]
      upstream_line_oe_out) else $error("upstream drive late");
endmodule
bind uir_repeater uir_repeater_chk u_chk (.clk_sys_in, .resetn_in,
  .upstream_line_out, .upstream_line_oe_out, .downstream_line_out,
  .downstream_line_oe_out, .downstream_speed_select_in, .pullup_enable_in,
  .upstream_powered_in, .downstream_powered_in, .upstream_pullup_dp_out,
  .upstream_pullup_dm_out, .downstream_pulldown_out, .state_out);

// >>> tb/testbench.sv
/* self-checking bench for uir_repeater.
   assumes the line models in uir_line_model. */
`timescale 1ns/1ps
module testbench;
  import uir_pkg::*;
  logic clk_sys_in = 0, resetn_in = 0, fs = 1, pu_en = 1;
  logic up_pwr = 1, dn_pwr = 1, up_oe, dn_oe, pu_dp, pu_dm, pd, pd_keep = 1;
  uir_line_t up_in, dn_in, up_out, dn_out;
  logic [1:0] st;
  int n_errors = 0, tests_run = 0, bc;
  initial forever #2 clk_sys_in = ~clk_sys_in;
  uir_repeater u_uir_repeater (.clk_sys_in, .resetn_in,
    .upstream_line_in(up_in), .upstream_line_out(up_out),
    .upstream_line_oe_out(up_oe), .downstream_line_in(dn_in),
    .downstream_line_out(dn_out), .downstream_line_oe_out(dn_oe),
    .upstream_speed_select_in(fs), .downstream_speed_select_in(fs),
    .pullup_enable_in(pu_en), .upstream_powered_in(up_pwr),
    .downstream_powered_in(dn_pwr), .pulldown_keep_strap_in(pd_keep),
    .upstream_pullup_dp_out(pu_dp), .upstream_pullup_dm_out(pu_dm),
    .downstream_pulldown_out(pd), .state_out(st));
  uir_line_model u_host (.clk_sys_in, .fs_in(fs), .oe_in(up_oe),
    .dut_in(up_out), .line_out(up_in));
  uir_line_model u_dev (.clk_sys_in, .fs_in(fs), .oe_in(dn_oe),
    .dut_in(dn_out), .line_out(dn_in));
  task automatic check(input string what, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic packet(input logic from_dn);
    logic [7:0] bits;
    int k;
    // bit 4 set keeps every J run shorter than the idle end
    bits = 8'($urandom) | 8'h11;
    fork
      if (from_dn) u_dev.send(bits);
      else u_host.send(bits);
      begin
        k = 0;
        while ((from_dn ? up_oe : dn_oe) !== 1'b1 && k < 400) begin
          cyc(1);
          k++;
        end
        check("start", {7'h0, k < 400}, 8'h01);
        cyc(bc / 2);
        for (int i = 0; i < 9; i++) begin
          check("sym", {6'h0, from_dn ? up_out : dn_out}, {6'h0, u_host.enc(
            i == 8 ? SYM_SE0 : bits[i] ? SYM_K : SYM_J)});
          check("rx quiet", {7'h0, from_dn ? dn_oe : up_oe}, 8'h0);
          cyc(bc);
        end
      end
    join
    k = 0;
    while (st !== 2'h0 && k < 2000) begin
      cyc(1);
      k++;
    end
    check("idle", {4'h0, st, up_oe, dn_oe}, 8'h0);
  endtask
  initial begin
    #400000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h6BF0));
    for (int s = 1; s >= 0; s--) begin
      cyc(1);
      resetn_in = 0;
      fs = s[0];
      pd_keep = s[0];
      bc = fs ? FS_BIT_CYC : LS_BIT_CYC;
      cyc(5);
      resetn_in = 1;
      check("reset", {6'h0, up_oe, dn_oe}, 8'h0);
      check("pulldown", {7'h0, pd}, 8'h01);
      cyc(40);
      check("pullup", {6'h0, pu_dp, pu_dm}, fs ? 8'h2 : 8'h1);
      check("pd strap", {7'h0, pd}, {7'h0, pd_keep});
      repeat (3) begin
        packet(0);
        packet(1);
      end
      pu_en = 0;
      fork
        u_host.send(8'h55);
        repeat (8) begin
          cyc(bc);
          check("detached", {4'h0, pu_dp, pu_dm, up_oe, dn_oe}, 8'h0);
        end
      join
      pu_en = 1;
      cyc(40);
      fork
        u_host.send(8'($urandom) | 8'h01);
        begin
          cyc(4 * bc);
          up_pwr = 0;
          cyc(PWR_LOSS_BITS * bc + 1);
          check("dn release", {7'h0, dn_oe}, 8'h0);
        end
      join
      up_pwr = 1;
      cyc(40);
      fork
        u_dev.send(8'($urandom) | 8'h01);
        begin
          cyc(4 * bc);
          dn_pwr = 0;
          cyc(PWR_LOSS_BITS * bc + 1);
          check("up release", {5'h0, pu_dp, pu_dm, up_oe}, 8'h0);
        end
      join
      dn_pwr = 1;
    end
    tally_and_finish;
  end
endmodule
